/* File: shared/insn_decoder_defs.svh */
`ifndef INSN_DECODER_DEFS_SVH
`define INSN_DECODER_DEFS_SVH

// Word layout
`define INSN_W 14
`define OPC_HI 13
`define OPC_LO 12
`define OP4_HI 11
`define OP4_LO 8
`define DEST_BIT 7
`define FADDR_HI 6
`define RADDR_HI 5
`define BIT_HI 8
`define BIT_LO 6
`define LIT_HI 7
`define TGT_HI 11
`define BOP_HI 10
`define BOP_LO 9
`define RHI_HI 7
`define RHI_LO 6

// Top-bit classes
`define CLS_BYTE 2'h0
`define CLS_BIT 2'h1
`define CLS_CALL 2'h2
`define CLS_JUMP 2'h3

// Byte-class four-bit codes
`define B_MISC 4'h0
`define B_CLR 4'h1
`define B_SUB 4'h2
`define B_DEC 4'h3
`define B_IOR 4'h4
`define B_AND 4'h5
`define B_XOR 4'h6
`define B_ADD 4'h7
`define B_MOVTST 4'h8
`define B_COM 4'h9
`define B_INC 4'ha
`define B_DECSKIP 4'hb
`define B_ROT_RIGHT 4'hc
`define B_ROT_LEFT 4'hd
`define B_SWAP 4'he
`define B_INCSKIP 4'hf

// Literal-class four-bit codes (bit 11 set)
`define L_RETLIT 4'h8
`define L_MOVLIT 4'h9
`define L_IORLIT 4'ha
`define L_ANDLIT 4'hb
`define L_ADDLIT 4'hc
`define L_XORLIT 4'hd
`define L_SYS 4'he
`define L_LOADR 4'hf

// Bit-class two-bit codes, bits 10..9
`define BO_CLR 2'h0
`define BO_SET 2'h1
`define BO_SKC 2'h2
`define BO_SKS 2'h3

// Whole-word codes
`define W_NOP 14'h0000
`define W_CLRW 14'h0140
`define W_RET 14'h0040
`define W_RET_INT 14'h0060
`define W_TAB_LO 14'h0050
`define W_TAB_HI 14'h0058
`define W_SLEEP 14'h1e03
`define W_WDTCLR 14'h1e04

// Wishbone register map
`define REG_CTRL 4'h0
`define REG_INSN 4'h4
`define REG_CLASS 4'h8
`define REG_FIELDS 4'hc
`define CTRL_RST 32'h0000_0000
`define ADR_HI 3
`define ADR_LO 2

`endif

/* File: shared/insn_decoder_pkg.sv */
package insn_decoder_pkg;

  typedef enum logic [4:0] {
    OP_NOP, OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_COM, OP_INC, OP_DEC,
    OP_INC_SKIP, OP_DEC_SKIP, OP_ROT_LEFT, OP_ROT_RIGHT, OP_SWAP, OP_CLR, OP_MOVE_IN,
    OP_MOVE_OUT, OP_TEST, OP_BIT_CLR, OP_BIT_SET, OP_SKIP_CLR, OP_SKIP_SET,
    OP_CALL, OP_JUMP, OP_RET, OP_RET_INT, OP_RET_LIT, OP_LOAD_LIT, OP_SLEEP,
    OP_WDT_CLR, OP_TAB_HI, OP_TAB_LO
  } alu_op_t;

  typedef enum logic [1:0] {
    DST_NONE, DST_WORK, DST_FILE, DST_RPLANE
  } dest_t;

  typedef enum logic [1:0] {
    CYC_ONE, CYC_TWO, CYC_SKIP
  } cycles_t;

  typedef enum logic [1:0] {
    SRC_FILE, SRC_LIT, SRC_RPLANE, SRC_NONE
  } src_t;

  typedef struct packed {
    logic carry;
    logic nibble_carry_flag;
    logic zero;
    logic timeout_flag;
    logic powerdown_flag;
  } flag_mask_t;

  typedef struct packed {
    alu_op_t op;
    dest_t dest;
    src_t src;
    cycles_t cycles;
    flag_mask_t flags;
    logic [6:0] faddr;
    logic [2:0] bit_idx;
    logic [7:0] literal;
    logic [11:0] target;
    logic illegal;
    logic stop_clock;
  } decode_t;

endpackage : insn_decoder_pkg

/* File: logic/fourteen_bit_insn_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
`include "insn_decoder_defs.svh"

// Summary of operation
// - Accept fourteen-bit words: opcode plus operand fields
// - Destination bit zero to work, one to file
// - Byte words: 00, opcode, destination, seven-bit address
// - Add register/literal one cycle, all arithmetic flags
// - Subtract updates C DC Z, carry means borrow
// - Rotates through carry, only carry changes, one cycle
// - Decrement-skip no flags, skip on zero, skip two cycles
// - Increment-skip no flags, skip on zero, skip two cycles
// - Store/load working to primary plane, no flags
// - Secondary-plane moves six-bit address, no flags
// - Bit clear/set: index, six-bit address, no flags
// - Bit test skips on match, skip two cycles
// - Call and jump twelve-bit target, two cycles
// - Literal and/or/xor with work, zero flag only
// - Load literal no flags; zero word is nop
// - Returns take two cycles; literal return loads work
// - Sleep stops clock; both touch timeout, powerdown
// - Table reads high/low into work, two cycles
// - Nibble carry holds mid-byte carry or borrow
module fourteen_bit_insn_decoder #(
  parameter int INSN_WIDTH = `INSN_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Program memory fetch
  input wire logic fetch_valid_i,
  input wire logic [INSN_WIDTH-1:0] fetch_word_i,
  // Classification result
  output logic decode_valid_o,
  output insn_decoder_pkg::decode_t decode_o,
  // Classic Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Word select: fetch port or software-injected word
  logic [31:0] ctrl;
  logic [INSN_WIDTH-1:0] sw_word;
  logic sw_go;
  wire sw_mode = ctrl[0];
  wire take = sw_mode ? sw_go : fetch_valid_i;
  wire [INSN_WIDTH-1:0] word = sw_mode ? sw_word : fetch_word_i;

  // Field extraction
  wire [1:0] cls = word[`OPC_HI:`OPC_LO];
  wire [3:0] op4 = word[`OP4_HI:`OP4_LO];
  wire dbit = word[`DEST_BIT];
  wire [6:0] faddr7 = word[`FADDR_HI:0];
  wire [6:0] raddr6 = {1'b0, word[`RADDR_HI:0]};
  wire [2:0] bidx = word[`BIT_HI:`BIT_LO];
  wire [7:0] lit = word[`LIT_HI:0];
  wire [11:0] tgt = word[`TGT_HI:0];
  wire lit_grp = word[`OP4_HI];
  wire [1:0] bop = word[`BOP_HI:`BOP_LO];
  wire dest_sel = dbit;
  wire rplane_hi_zero = (word[`RHI_HI:`RHI_LO] == 2'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Decode table
  insn_decoder_pkg::decode_t next_dec;
  always_comb begin
    next_dec = '0;
    next_dec.op = insn_decoder_pkg::OP_NOP;
    next_dec.dest = insn_decoder_pkg::DST_NONE;
    next_dec.src = insn_decoder_pkg::SRC_NONE;
    next_dec.cycles = insn_decoder_pkg::CYC_ONE;
    next_dec.faddr = faddr7;
    next_dec.bit_idx = bidx;
    next_dec.literal = lit;
    next_dec.target = tgt;
    case (cls)
      `CLS_BYTE: begin
        next_dec.src = insn_decoder_pkg::SRC_FILE;
        next_dec.dest = dest_sel ? insn_decoder_pkg::DST_FILE
                                 : insn_decoder_pkg::DST_WORK;
        case (op4)
          // Full arithmetic flags
          `B_ADD: begin
            next_dec.op = insn_decoder_pkg::OP_ADD;
            next_dec.flags = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
          end

          `B_SUB: begin
            next_dec.op = insn_decoder_pkg::OP_SUB; // Carry is borrow
            next_dec.flags = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
          end

          // Zero flag only
          `B_AND: begin
            next_dec.op = insn_decoder_pkg::OP_AND;
            next_dec.flags.zero = 1'b1;
          end

          `B_IOR: begin
            next_dec.op = insn_decoder_pkg::OP_IOR;
            next_dec.flags.zero = 1'b1;
          end

          `B_XOR: begin
            next_dec.op = insn_decoder_pkg::OP_XOR;
            next_dec.flags.zero = 1'b1;
          end

          `B_COM: begin
            next_dec.op = insn_decoder_pkg::OP_COM;
            next_dec.flags.zero = 1'b1;
          end

          `B_INC: begin
            next_dec.op = insn_decoder_pkg::OP_INC;
            next_dec.flags.zero = 1'b1;
          end

          `B_DEC: begin
            next_dec.op = insn_decoder_pkg::OP_DEC;
            next_dec.flags.zero = 1'b1;
          end

          // Skips, no flags
          `B_DECSKIP: begin
            next_dec.op = insn_decoder_pkg::OP_DEC_SKIP;
            next_dec.cycles = insn_decoder_pkg::CYC_SKIP;
          end

          `B_INCSKIP: begin
            next_dec.op = insn_decoder_pkg::OP_INC_SKIP;
            next_dec.cycles = insn_decoder_pkg::CYC_SKIP;
          end

          // Rotates
          `B_ROT_LEFT: begin
            next_dec.op = insn_decoder_pkg::OP_ROT_LEFT;
            next_dec.flags.carry = 1'b1;
          end

          `B_ROT_RIGHT: begin
            next_dec.op = insn_decoder_pkg::OP_ROT_RIGHT;
            next_dec.flags.carry = 1'b1;
          end

          `B_SWAP: next_dec.op = insn_decoder_pkg::OP_SWAP;

          `B_CLR: begin
            next_dec.flags.zero = 1'b1;
            if (dbit) begin
              next_dec.op = insn_decoder_pkg::OP_CLR;
            end else begin
              next_dec.op = insn_decoder_pkg::OP_CLR;
              next_dec.dest = insn_decoder_pkg::DST_WORK;
              next_dec.src = insn_decoder_pkg::SRC_NONE;
              next_dec.illegal = (word != `W_CLRW);
            end
          end

          `B_MOVTST: begin
            if (dbit) begin
              next_dec.op = insn_decoder_pkg::OP_TEST;
              next_dec.dest = insn_decoder_pkg::DST_NONE;
              next_dec.flags.zero = 1'b1;
            end else begin
              next_dec.op = insn_decoder_pkg::OP_MOVE_IN;
              next_dec.dest = insn_decoder_pkg::DST_WORK;
            end
          end

          // Whole words
          `B_MISC: begin
            if (dbit) begin
              next_dec.op = insn_decoder_pkg::OP_MOVE_OUT;
              next_dec.dest = insn_decoder_pkg::DST_FILE;
            end else begin
              next_dec.src = insn_decoder_pkg::SRC_NONE;
              next_dec.dest = insn_decoder_pkg::DST_NONE;
              case (word)
                `W_NOP: next_dec.op = insn_decoder_pkg::OP_NOP;

                `W_RET: begin
                  next_dec.op = insn_decoder_pkg::OP_RET;
                  next_dec.cycles = insn_decoder_pkg::CYC_TWO;
                end

                `W_RET_INT: begin
                  next_dec.op = insn_decoder_pkg::OP_RET_INT;
                  next_dec.cycles = insn_decoder_pkg::CYC_TWO;
                end

                `W_TAB_HI: begin
                  next_dec.op = insn_decoder_pkg::OP_TAB_HI;
                  next_dec.dest = insn_decoder_pkg::DST_WORK;
                  next_dec.cycles = insn_decoder_pkg::CYC_TWO;
                end

                `W_TAB_LO: begin
                  next_dec.op = insn_decoder_pkg::OP_TAB_LO;
                  next_dec.dest = insn_decoder_pkg::DST_WORK;
                  next_dec.cycles = insn_decoder_pkg::CYC_TWO;
                end
                default: next_dec.illegal = 1'b1;
              endcase
            end
          end
          default: next_dec.illegal = 1'b1;
        endcase
      end

      // Bit and literal ops
      `CLS_BIT: begin
        if (!lit_grp) begin
          next_dec.faddr = raddr6;
          next_dec.src = insn_decoder_pkg::SRC_FILE;
          case (bop)
            `BO_CLR: begin
              next_dec.op = insn_decoder_pkg::OP_BIT_CLR;
              next_dec.dest = insn_decoder_pkg::DST_FILE;
            end

            `BO_SET: begin
              next_dec.op = insn_decoder_pkg::OP_BIT_SET;
              next_dec.dest = insn_decoder_pkg::DST_FILE;
            end

            `BO_SKC: begin
              next_dec.op = insn_decoder_pkg::OP_SKIP_CLR;
              next_dec.cycles = insn_decoder_pkg::CYC_SKIP;
            end
            default: begin
              next_dec.op = insn_decoder_pkg::OP_SKIP_SET;
              next_dec.cycles = insn_decoder_pkg::CYC_SKIP;
            end
          endcase
        end else begin
          next_dec.src = insn_decoder_pkg::SRC_LIT;
          next_dec.dest = insn_decoder_pkg::DST_WORK;
          case (op4)
            // Literal ops
            `L_ADDLIT: begin
              next_dec.op = insn_decoder_pkg::OP_ADD;
              next_dec.flags = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
            end

            `L_ANDLIT: begin
              next_dec.op = insn_decoder_pkg::OP_AND;
              next_dec.flags.zero = 1'b1;
            end

            `L_IORLIT: begin
              next_dec.op = insn_decoder_pkg::OP_IOR;
              next_dec.flags.zero = 1'b1;
            end

            `L_XORLIT: begin
              next_dec.op = insn_decoder_pkg::OP_XOR;
              next_dec.flags.zero = 1'b1;
            end

            `L_MOVLIT: next_dec.op = insn_decoder_pkg::OP_LOAD_LIT;

            `L_RETLIT: begin
              next_dec.op = insn_decoder_pkg::OP_RET_LIT;
              next_dec.cycles = insn_decoder_pkg::CYC_TWO;
            end

            `L_LOADR: begin
              next_dec.op = insn_decoder_pkg::OP_MOVE_IN;
              next_dec.src = insn_decoder_pkg::SRC_RPLANE;
              next_dec.faddr = raddr6;
              next_dec.illegal = !rplane_hi_zero;
            end

            `L_SYS: begin
              next_dec.src = insn_decoder_pkg::SRC_NONE;
              next_dec.dest = insn_decoder_pkg::DST_NONE;
              if (word == `W_SLEEP) begin
                next_dec.op = insn_decoder_pkg::OP_SLEEP;
                next_dec.stop_clock = 1'b1;
                next_dec.flags.timeout_flag = 1'b1;
                next_dec.flags.powerdown_flag = 1'b1;
              end else if (word == `W_WDTCLR) begin
                next_dec.op = insn_decoder_pkg::OP_WDT_CLR;
                next_dec.flags.timeout_flag = 1'b1;
                next_dec.flags.powerdown_flag = 1'b1;
              end else begin
                next_dec.op = insn_decoder_pkg::OP_MOVE_OUT;
                next_dec.dest = insn_decoder_pkg::DST_RPLANE;
                next_dec.faddr = raddr6;
                next_dec.illegal = !rplane_hi_zero;
              end
            end
            default: next_dec.illegal = 1'b1;
          endcase
        end
      end

      // Branches
      `CLS_CALL: begin
        next_dec.op = insn_decoder_pkg::OP_CALL;
        next_dec.cycles = insn_decoder_pkg::CYC_TWO;
      end
      default: begin
        next_dec.op = insn_decoder_pkg::OP_JUMP;
        next_dec.cycles = insn_decoder_pkg::CYC_TWO;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      decode_o <= '0;
      decode_valid_o <= 1'b0;
    end else begin
      decode_valid_o <= take;
      if (take) begin
        decode_o <= next_dec;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone decode
  wire req = cyc_i && stb_i && !ack_o && !err_o;
  wire hit_ctrl = (adr_i == `REG_CTRL);
  wire hit_insn = (adr_i == `REG_INSN);
  wire hit_class = (adr_i == `REG_CLASS);
  wire hit_fields = (adr_i == `REG_FIELDS);
  wire mapped = hit_ctrl || hit_insn || hit_class || hit_fields;
  wire wr_ctrl = req && we_i && hit_ctrl && sel_i[0];
  wire wr_insn = req && we_i && hit_insn && (sel_i[1:0] == 2'h3);
  wire [31:0] class_word = {6'h0, decode_o.illegal, decode_o.stop_clock,
                            decode_o.flags, decode_o.cycles, decode_o.src,
                            decode_o.dest, decode_o.op, 8'h0};
  wire [31:0] field_word = {decode_o.target, decode_o.literal, 2'h0,
                            decode_o.bit_idx, decode_o.faddr};
  wire [31:0] rd_mux = hit_ctrl ? ctrl :
                       hit_insn ? {18'h0, sw_word} :
                       hit_class ? class_word : field_word;

  // Register writes and answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `CTRL_RST;
      sw_word <= '0;
      sw_go <= 1'b0;
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= req && mapped;
      err_o <= req && !mapped;
      sw_go <= wr_insn; // Decode one cycle after write
      if (wr_ctrl) begin
        ctrl <= {31'h0, dat_i[0]};
      end
      if (wr_insn) begin
        sw_word <= dat_i[INSN_WIDTH-1:0];
      end
      if (req) begin
        dat_o <= mapped ? rd_mux : 32'h0;
      end
    end
  end

endmodule : fourteen_bit_insn_decoder
`default_nettype wire

/* File: verif/insn_decoder_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "insn_decoder_defs.svh"
module insn_decoder_checker #(
  parameter int INSN_WIDTH = `INSN_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fetch_valid_i,
  input wire logic [INSN_WIDTH-1:0] fetch_word_i,
  input wire logic decode_valid_o,
  input wire insn_decoder_pkg::decode_t decode_o,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic err_o
);
  logic sw_mode;
  logic [INSN_WIDTH-1:0] w;
  wire fv;
  ////////////////////////////////////////////////////////////////
  // Word source select and last fetched word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_mode <= 1'b0;
    end else if (ack_o && we_i && adr_i == `REG_CTRL && sel_i[0]) begin
      sw_mode <= dat_i[0];
    end
    w <= fetch_word_i;
  end
  assign fv = decode_valid_o && !sw_mode; // Decode came from fetch port
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_fetch_answer: assert property (
    fetch_valid_i && !sw_mode |=> decode_valid_o) else $error("fetch not answered");
  a_dest_steer: assert property (fv && w[13:8] == 6'h07 |->
    decode_o.dest == (w[7] ? insn_decoder_pkg::DST_FILE : insn_decoder_pkg::DST_WORK)
    && decode_o.faddr == w[6:0]) else $error("byte dest or address wrong");
  a_add_flags: assert property (fv && w[13:8] inside {6'h07, 6'h1c} |->
    decode_o.flags == 5'h1c && decode_o.cycles == insn_decoder_pkg::CYC_ONE)
    else $error("add flags wrong");
  a_sub_flags: assert property (
    fv && w[13:8] == 6'h02 |-> decode_o.flags == 5'h1c) else $error("sub flags wrong");
  a_rotate_carry: assert property (fv && w[13:9] == 5'h06 |->
    decode_o.flags == 5'h10 && decode_o.cycles == insn_decoder_pkg::CYC_ONE)
    else $error("rotate flags wrong");
  a_skip_noflag: assert property (fv && w[13:8] inside {6'h0b, 6'h0f} |->
    decode_o.flags == 5'h00 && decode_o.cycles == insn_decoder_pkg::CYC_SKIP)
    else $error("skip decode wrong");
  a_bit_fields: assert property (fv && w[13:11] == 3'h2 |->
    decode_o.bit_idx == w[8:6] && decode_o.faddr == {1'b0, w[5:0]}
    && decode_o.flags == 5'h00) else $error("bit fields wrong");
  a_branch_two: assert property (fv && w[13] |->
    decode_o.target == w[11:0] && decode_o.cycles == insn_decoder_pkg::CYC_TWO)
    else $error("branch decode wrong");
  a_lit_zero: assert property (
    fv && w[13:8] inside {6'h1a, 6'h1b, 6'h1d} |-> decode_o.flags == 5'h04)
    else $error("literal logic flags wrong");
  a_sleep_stop: assert property (
    fv && w == `W_SLEEP |-> decode_o.stop_clock && decode_o.flags == 5'h03)
    else $error("sleep decode wrong");
  a_bus_answer: assert property (
    $rose(cyc_i && stb_i) |-> ##[1:2] (ack_o || err_o)) else $error("bus not answered");
  c_add_seen: cover property (fv && w[13:8] == 6'h07);
  c_skip_seen: cover property (fv && decode_o.cycles == insn_decoder_pkg::CYC_SKIP);
  c_err_seen: cover property (err_o);
endmodule : insn_decoder_checker
bind fourteen_bit_insn_decoder insn_decoder_checker #(.INSN_WIDTH(INSN_WIDTH)) i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .fetch_valid_i(fetch_valid_i),
  .fetch_word_i(fetch_word_i), .decode_valid_o(decode_valid_o), .decode_o(decode_o),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o));
`default_nettype wire

/* File: verif/prog_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic [13:0] word_i,
  output logic fetch_valid_o,
  output logic [13:0] fetch_word_o
);
  // One whole word per request; idle bus inverts the last word on every cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      fetch_valid_o <= 1'b0;
      fetch_word_o <= 14'h0000;
    end else if (!go_i) begin
      fetch_valid_o <= 1'b0;
      fetch_word_o <= ~fetch_word_o;
    end else begin
      fetch_valid_o <= 1'b1;
      fetch_word_o <= word_i;
    end
  end
endmodule : prog_mem_model
`default_nettype wire

/* File: verif/fourteen_bit_insn_decoder_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "insn_decoder_defs.svh"
module fourteen_bit_insn_decoder_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic go = 1'b0;
  logic [13:0] nw = 14'h0000;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [3:0] adr_i = 4'h0;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0000_0000;
  logic fetch_valid_i;
  logic [13:0] fetch_word_i;
  logic decode_valid_o;
  insn_decoder_pkg::decode_t decode_o;
  logic [31:0] dat_o;
  logic ack_o;
  logic err_o;
  logic [31:0] q;
  logic e;
  int fails = 0;
  int compares = 0;
  int cycles_run = 0;
  ////////////////////////////////////////////////////////////////
  fourteen_bit_insn_decoder i_fourteen_bit_insn_decoder (
    .clk_i(clk_i), .rst_i(rst_i), .fetch_valid_i(fetch_valid_i),
    .fetch_word_i(fetch_word_i), .decode_valid_o(decode_valid_o), .decode_o(decode_o),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o));
  prog_mem_model i_prog_mem_model (
    .clk_i(clk_i), .rst_i(rst_i), .go_i(go), .word_i(nw),
    .fetch_valid_o(fetch_valid_i), .fetch_word_o(fetch_word_i));
  // Clock at 50 ns and hang guard
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles_run++;
    if (cycles_run == 3000) begin
      fails++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task wait_dv;
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (decode_valid_o !== 1'b1 && n < 5);
    check("decode valid", decode_valid_o, 32'h1);
  endtask : wait_dv
  task fetch(input logic [13:0] w);
    @(posedge clk_i);
    go <= 1'b1;
    nw <= w;
    @(posedge clk_i);
    go <= 1'b0;
    wait_dv();
  endtask : fetch
  task dec(input logic [13:0] w, input insn_decoder_pkg::alu_op_t op,
           input logic [1:0] ds, input logic [1:0] cy, input logic [4:0] fl);
    fetch(w);
    check("op", decode_o.op, op);
    check("dest", decode_o.dest, ds);
    check("cycles", decode_o.cycles, cy);
    check("flags", decode_o.flags, fl);
  endtask : dec
  // Move words: destination, address, one cycle, no flags
  task mv(input logic [13:0] w, input logic [1:0] ds, input logic [6:0] fa);
    fetch(w);
    check("dest", decode_o.dest, ds);
    check("faddr", decode_o.faddr, fa);
    check("cycles", decode_o.cycles, 32'h0);
    check("flags", decode_o.flags, 32'h0);
  endtask : mv
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d,
          output logic [31:0] r, output logic er);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1 && err_o !== 1'b1);
    r = dat_o;
    er = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb
  ////////////////////////////////////////////////////////////////
  task t_byte;
    dec(14'h0725, insn_decoder_pkg::OP_ADD, 2'h1, 2'h0, 5'h1c);
    check("faddr", decode_o.faddr, 32'h25);
    dec(14'h07ff, insn_decoder_pkg::OP_ADD, 2'h2, 2'h0, 5'h1c);
    check("faddr", decode_o.faddr, 32'h7f);
    dec(14'h0280, insn_decoder_pkg::OP_SUB, 2'h2, 2'h0, 5'h1c);
    dec(14'h0511, insn_decoder_pkg::OP_AND, 2'h1, 2'h0, 5'h04);
    dec(14'h0491, insn_decoder_pkg::OP_IOR, 2'h2, 2'h0, 5'h04);
    dec(14'h0611, insn_decoder_pkg::OP_XOR, 2'h1, 2'h0, 5'h04);
    dec(14'h0991, insn_decoder_pkg::OP_COM, 2'h2, 2'h0, 5'h04);
    dec(14'h0a11, insn_decoder_pkg::OP_INC, 2'h1, 2'h0, 5'h04);
    dec(14'h0391, insn_decoder_pkg::OP_DEC, 2'h2, 2'h0, 5'h04);
    dec(14'h0140, insn_decoder_pkg::OP_CLR, 2'h1, 2'h0, 5'h04);
    dec(14'h0d7f, insn_decoder_pkg::OP_ROT_LEFT, 2'h1, 2'h0, 5'h10);
    dec(14'h0c80, insn_decoder_pkg::OP_ROT_RIGHT, 2'h2, 2'h0, 5'h10);
    dec(14'h0b05, insn_decoder_pkg::OP_DEC_SKIP, 2'h1, 2'h2, 5'h00);
    dec(14'h0f85, insn_decoder_pkg::OP_INC_SKIP, 2'h2, 2'h2, 5'h00);
    mv(14'h00aa, 2'h2, 7'h2a);
    mv(14'h087f, 2'h1, 7'h7f);
    mv(14'h1e15, 2'h3, 7'h15);
    mv(14'h1f3f, 2'h1, 7'h3f);
  endtask : t_byte
  task t_bit;
    dec(14'h1155, insn_decoder_pkg::OP_BIT_CLR, 2'h2, 2'h0, 5'h00);
    check("bit", decode_o.bit_idx, 32'h5);
    check("faddr", decode_o.faddr, 32'h15);
    dec(14'h1355, insn_decoder_pkg::OP_BIT_SET, 2'h2, 2'h0, 5'h00);
    dec(14'h1500, insn_decoder_pkg::OP_SKIP_CLR, 2'h0, 2'h2, 5'h00);
    dec(14'h17ff, insn_decoder_pkg::OP_SKIP_SET, 2'h0, 2'h2, 5'h00);
    check("bit", decode_o.bit_idx, 32'h7);
    check("faddr", decode_o.faddr, 32'h3f);
  endtask : t_bit
  task t_lit;
    dec(14'h1c80, insn_decoder_pkg::OP_ADD, 2'h1, 2'h0, 5'h1c);
    check("literal", decode_o.literal, 32'h80);
    dec(14'h1b0f, insn_decoder_pkg::OP_AND, 2'h1, 2'h0, 5'h04);
    dec(14'h1af0, insn_decoder_pkg::OP_IOR, 2'h1, 2'h0, 5'h04);
    dec(14'h1d3c, insn_decoder_pkg::OP_XOR, 2'h1, 2'h0, 5'h04);
    dec(14'h19ff, insn_decoder_pkg::OP_LOAD_LIT, 2'h1, 2'h0, 5'h00);
    check("literal", decode_o.literal, 32'hff);
    dec(14'h0000, insn_decoder_pkg::OP_NOP, 2'h0, 2'h0, 5'h00);
    check("illegal", decode_o.illegal, 32'h0);
    dec(14'h0001, insn_decoder_pkg::OP_NOP, 2'h0, 2'h0, 5'h00);
    check("illegal", decode_o.illegal, 32'h1);
    dec(14'h0040, insn_decoder_pkg::OP_RET, 2'h0, 2'h1, 5'h00);
    dec(14'h0060, insn_decoder_pkg::OP_RET_INT, 2'h0, 2'h1, 5'h00);
    dec(14'h18a5, insn_decoder_pkg::OP_RET_LIT, 2'h1, 2'h1, 5'h00);
    check("literal", decode_o.literal, 32'ha5);
    dec(14'h1e03, insn_decoder_pkg::OP_SLEEP, 2'h0, 2'h0, 5'h03);
    check("stop", decode_o.stop_clock, 32'h1);
    dec(14'h1e04, insn_decoder_pkg::OP_WDT_CLR, 2'h0, 2'h0, 5'h03);
    check("stop", decode_o.stop_clock, 32'h0);
    dec(14'h0058, insn_decoder_pkg::OP_TAB_HI, 2'h1, 2'h1, 5'h00);
    dec(14'h0050, insn_decoder_pkg::OP_TAB_LO, 2'h1, 2'h1, 5'h00);
    dec(14'h2fff, insn_decoder_pkg::OP_CALL, 2'h0, 2'h1, 5'h00);
    check("target", decode_o.target, 32'hfff);
    dec(14'h3000, insn_decoder_pkg::OP_JUMP, 2'h0, 2'h1, 5'h00);
    check("target", decode_o.target, 32'h0);
  endtask : t_lit
  // Two words on consecutive cycles
  task t_burst;
    @(posedge clk_i);
    go <= 1'b1;
    nw <= 14'h0040;
    @(posedge clk_i);
    nw <= 14'h1c01;
    @(posedge clk_i);
    go <= 1'b0;
    @(negedge clk_i);
    check("burst first op", decode_o.op, insn_decoder_pkg::OP_RET);
    @(negedge clk_i);
    check("burst valid", decode_valid_o, 32'h1);
    check("burst op", decode_o.op, insn_decoder_pkg::OP_ADD);
  endtask : t_burst
  // Software word source, refused fetch, unmapped access
  task t_wb;
    wb(1'b1, `REG_CTRL, 32'h1, q, e);
    check("ctrl err", e, 32'h0);
    wb(1'b1, `REG_INSN, 32'h0f85, q, e);
    wait_dv();
    check("sw op", decode_o.op, insn_decoder_pkg::OP_INC_SKIP);
    wb(1'b0, `REG_CLASS, 32'h0, q, e);
    check("class cycles", q[18:17], insn_decoder_pkg::CYC_SKIP);
    wb(1'b0, `REG_FIELDS, 32'h0, q, e);
    check("fields", q, 32'hf858_5305);
    wb(1'b0, `REG_CTRL, 32'h0, q, e);
    check("ctrl read", q[0], 32'h1);
    @(posedge clk_i);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (3) begin
      @(negedge clk_i);
      check("fetch refused", decode_valid_o, 32'h0);
    end
    wb(1'b1, 4'h2, 32'h0, q, e);
    check("unmapped err", e, 32'h1);
    wb(1'b1, `REG_CTRL, 32'h0, q, e);
  endtask : t_wb
  task end_of_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_byte();
    $display("byte test done");
    t_bit();
    $display("bit test done");
    t_lit();
    $display("literal test done");
    t_burst();
    $display("burst test done");
    t_wb();
    $display("bus test done");
    end_of_test();
  end
endmodule : fourteen_bit_insn_decoder_tb
`default_nettype wire
